// [verilog/gpsm_cfg.svh]
// register offsets, field positions, function codes and reset values
`ifndef GPSM_CFG_SVH
`define GPSM_CFG_SVH
`define GPSM_ADDR_W 12
`define GPSM_ADDR_STATUS0 12'h033
`define GPSM_ADDR_STATUS1 12'h034
`define GPSM_ADDR_PIN1_PIN0 12'h035
`define GPSM_ADDR_PIN3_PIN2 12'h036
`define GPSM_ADDR_PIN5_PIN4 12'h037
`define GPSM_ADDR_SYNC_PORT 12'h038
`define GPSM_ADDR_SYNC_MODE 12'h42A
`define GPSM_FIELD_HI 7
`define GPSM_FIELD_HI_LSB 4
`define GPSM_FIELD_LO 3
`define GPSM_FIELD_LO_LSB 0
`define GPSM_MODE_BIT 0
`define GPSM_CFG_RESET 8'h00
`define GPSM_CODE_HIZ 4'h0
`define GPSM_CODE_1 4'h1
`define GPSM_CODE_2 4'h2
`define GPSM_CODE_3 4'h3
`define GPSM_CODE_DIFF 4'h9
`define GPSM_CODE_MASTER 4'hA
`define GPSM_CODE_SLAVE 4'hB
`define GPSM_NUM_PINS 6
`define GPSM_NUM_HOP 7
`endif

// [verilog/gpsm_pkg.sv]
// types shared by the pin function multiplexer
package gpsm_pkg;
  typedef logic [3:0] gpsm_code_t;
  typedef logic [7:0] gpsm_byte_t;
endpackage

// [verilog/gpsm_sync_if.sv]
// raw and synchronised pin levels between the mux and its synchroniser
interface gpsm_sync_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport mux (output raw, input synced);
  modport sync (input raw, output synced);
endinterface

// [verilog/gpsm_pin_sync.sv]
// two-flop synchroniser for all pin inputs
module gpsm_pin_sync
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  gpsm_sync_if.sync sif
);
  logic [$bits(sif.raw)-1:0] meta_q;
  logic [$bits(sif.raw)-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= sif.raw;
      sync_q <= meta_q;
    end
  end

  assign sif.synced = sync_q;
endmodule

// [verilog/gpsm_mux.sv]
// function multiplexer for general pins 0..5 and the second sync port
// Overview of operation
// - pin field 0xA drives that pin with the nco master sync output
// - pin field 0xB takes that pin as the nco slave sync input
// - pin 5 field 0x2 makes it a strobe latching all hop selects
// - sync port negative pin field sits at bits [7:4] of 0x038
// - sync port positive pin field sits at bits [3:0] of 0x038
// - bit 0 of 0x42A picks single-ended or differential sync port
// - negative code 0x0 is high-z, or differential half when mode is 1 and positive code is 0x9
// - negative code 0x1 is an input for hop select bit 1
// - positive code 0x1 drives the sync request single-ended
// - positive code 0x3 is an input for hop select bit 0
// - positive code 0x9 drives sync request differentially when mode is 1 and negative code is 0x0
// - a status bit shows pin 5 level when used as hop strobe
// - status 0x033 bit 7 shows transmit enable 1 from pin 4
`include "gpsm_cfg.svh"
module gpsm_mux
  import gpsm_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [`GPSM_ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [`GPSM_NUM_PINS-1:0] gpio_in,
  output logic [`GPSM_NUM_PINS-1:0] gpio_out,
  output logic [`GPSM_NUM_PINS-1:0] gpio_oe_out,
  input wire logic sync_pos_in,
  output logic sync_pos_out,
  output logic sync_pos_oe_out,
  input wire logic sync_neg_in,
  output logic sync_neg_out,
  output logic sync_neg_oe_out,
  input wire logic [3:0] power_amp_enable_in,
  input wire logic nco_master_in,
  output logic nco_slave_out,
  input wire logic second_sync_request_in,
  output logic transmit_enable_1_out,
  output logic transmit_enable_3_out,
  output logic [`GPSM_NUM_HOP-1:0] hop_select_out
);
  gpsm_byte_t cfg01_q;
  gpsm_byte_t cfg23_q;
  gpsm_byte_t cfg45_q;
  gpsm_byte_t cfgsync_q;
  logic sync_port_differential_mode_q;
  gpsm_byte_t rdata_d;
  gpsm_code_t field [`GPSM_NUM_PINS];
  gpsm_code_t sync_port_neg_function_field;
  gpsm_code_t sync_port_pos_function_field;
  logic [`GPSM_NUM_PINS-1:0] pin_s;
  logic pos_s;
  logic neg_s;
  logic [`GPSM_NUM_PINS-1:0] pin_out_d;
  logic [`GPSM_NUM_PINS-1:0] pin_oe_d;
  logic [`GPSM_NUM_PINS-1:0] slave_hit;
  logic [`GPSM_NUM_HOP-1:0] hop_raw;
  logic [`GPSM_NUM_HOP-1:0] hop_q;
  logic strobe_mode;
  logic strobe_prev_q;
  logic strobe_rise;
  logic diff_drive;
  logic neg_diff;
  logic pos_oe_d;
  logic pos_out_d;
  logic neg_oe_d;
  logic neg_out_d;
  logic tx_en_1_lvl;
  logic tx_en_3_lvl;
  logic strobe_lvl;
  gpsm_byte_t status0;
  gpsm_byte_t status1;
  logic [`GPSM_NUM_PINS-1:0] gpio_out_q;
  logic [`GPSM_NUM_PINS-1:0] gpio_oe_q;
  logic pos_out_q;
  logic pos_oe_q;
  logic neg_out_q;
  logic neg_oe_q;
  logic slave_q;
  logic tx_en_1_q;
  logic tx_en_3_q;
  gpsm_byte_t rdata_q;

  gpsm_sync_if #(.WIDTH(`GPSM_NUM_PINS + 2)) sif ();

  gpsm_pin_sync u_sync
  (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .sif(sif.sync)
  );

  assign sif.raw = {sync_neg_in, sync_pos_in, gpio_in};
  assign pin_s = sif.synced[`GPSM_NUM_PINS-1:0];
  assign pos_s = sif.synced[`GPSM_NUM_PINS];
  assign neg_s = sif.synced[`GPSM_NUM_PINS+1];

  // register write port; fields reset to high-z
  wire wr01 = reg_wr_in && (reg_addr_in == `GPSM_ADDR_PIN1_PIN0);
  wire wr23 = reg_wr_in && (reg_addr_in == `GPSM_ADDR_PIN3_PIN2);
  wire wr45 = reg_wr_in && (reg_addr_in == `GPSM_ADDR_PIN5_PIN4);
  wire wrsp = reg_wr_in && (reg_addr_in == `GPSM_ADDR_SYNC_PORT);
  wire wrmd = reg_wr_in && (reg_addr_in == `GPSM_ADDR_SYNC_MODE);

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cfg01_q <= `GPSM_CFG_RESET;
      cfg23_q <= `GPSM_CFG_RESET;
      cfg45_q <= `GPSM_CFG_RESET;
      cfgsync_q <= `GPSM_CFG_RESET;
      sync_port_differential_mode_q <= 1'b0;
    end
    else
    begin
      if (wr01)
        cfg01_q <= reg_wdata_in;
      if (wr23)
        cfg23_q <= reg_wdata_in;
      if (wr45)
        cfg45_q <= reg_wdata_in;
      if (wrsp)
        cfgsync_q <= reg_wdata_in;
      if (wrmd)
        sync_port_differential_mode_q <= reg_wdata_in[`GPSM_MODE_BIT];
    end
  end

  assign field[0] = cfg01_q[`GPSM_FIELD_LO:`GPSM_FIELD_LO_LSB];
  assign field[1] = cfg01_q[`GPSM_FIELD_HI:`GPSM_FIELD_HI_LSB];
  assign field[2] = cfg23_q[`GPSM_FIELD_LO:`GPSM_FIELD_LO_LSB];
  assign field[3] = cfg23_q[`GPSM_FIELD_HI:`GPSM_FIELD_HI_LSB];
  assign field[4] = cfg45_q[`GPSM_FIELD_LO:`GPSM_FIELD_LO_LSB];
  assign field[5] = cfg45_q[`GPSM_FIELD_HI:`GPSM_FIELD_HI_LSB];
  assign sync_port_neg_function_field =
    cfgsync_q[`GPSM_FIELD_HI:`GPSM_FIELD_HI_LSB];
  assign sync_port_pos_function_field =
    cfgsync_q[`GPSM_FIELD_LO:`GPSM_FIELD_LO_LSB];

  // per-pin drive decode; pin 3 uses code 0x2 for its amp enable
  genvar i;
  generate
    for (i = 0; i < `GPSM_NUM_PINS; i++)
    begin : g_pin
      localparam gpsm_code_t PA_CODE = (i == 3) ? `GPSM_CODE_2 : `GPSM_CODE_1;
      wire is_master = (field[i] == `GPSM_CODE_MASTER);
      wire is_pa = (i < 4) && (field[i] == PA_CODE);
      assign pin_oe_d[i] = is_master || is_pa;
      assign pin_out_d[i] = is_master ? nco_master_in
        : (is_pa && power_amp_enable_in[i % 4]);
      assign slave_hit[i] = (field[i] == `GPSM_CODE_SLAVE) && pin_s[i];
    end
    for (i = 0; i < 4; i++)
    begin : g_hop
      // pins 0..3 carry hop selects 2..5 on code 0x3
      assign hop_raw[i + 2] = (field[i] == `GPSM_CODE_3) && pin_s[i];
    end
  endgenerate

  assign hop_raw[6] = (field[4] == `GPSM_CODE_2) && pin_s[4];
  assign hop_raw[1] = (sync_port_neg_function_field == `GPSM_CODE_1)
    && neg_s;
  assign hop_raw[0] = (sync_port_pos_function_field == `GPSM_CODE_3)
    && pos_s;
  assign tx_en_1_lvl = (field[4] == `GPSM_CODE_1) && pin_s[4];
  assign tx_en_3_lvl = (field[5] == `GPSM_CODE_1) && pin_s[5];
  assign strobe_mode = (field[5] == `GPSM_CODE_2);
  assign strobe_lvl = strobe_mode && pin_s[5];
  assign strobe_rise = strobe_lvl && !strobe_prev_q;

  // sync port: differential only with mode bit and matching codes
  assign diff_drive = sync_port_differential_mode_q
    && (sync_port_pos_function_field == `GPSM_CODE_DIFF);
  assign neg_diff = diff_drive
    && (sync_port_neg_function_field == `GPSM_CODE_HIZ);
  assign pos_oe_d = diff_drive
    || (sync_port_pos_function_field == `GPSM_CODE_1);
  assign pos_out_d = pos_oe_d && second_sync_request_in;
  assign neg_oe_d = neg_diff;
  assign neg_out_d = neg_diff && !second_sync_request_in;

  // reserved status bits read as zero
  assign status0 = {tx_en_1_lvl, hop_raw[5], hop_raw[4], 1'b0,
    hop_raw[3], 1'b0, hop_raw[2], 1'b0};
  assign status1 = {3'h0, hop_raw[1], hop_raw[0], strobe_lvl,
    tx_en_3_lvl, hop_raw[6]};

  always_comb
  begin
    unique case (reg_addr_in)
      `GPSM_ADDR_STATUS0: rdata_d = status0;
      `GPSM_ADDR_STATUS1: rdata_d = status1;
      `GPSM_ADDR_PIN1_PIN0: rdata_d = cfg01_q;
      `GPSM_ADDR_PIN3_PIN2: rdata_d = cfg23_q;
      `GPSM_ADDR_PIN5_PIN4: rdata_d = cfg45_q;
      `GPSM_ADDR_SYNC_PORT: rdata_d = cfgsync_q;
      `GPSM_ADDR_SYNC_MODE: rdata_d = {7'h00, sync_port_differential_mode_q};
      default: rdata_d = 8'h00;
    endcase
  end

  // hop selects follow the pins unless a strobe pin is set up to latch them
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      hop_q <= '0;
      strobe_prev_q <= 1'b0;
    end
    else
    begin
      strobe_prev_q <= strobe_lvl;
      if (!strobe_mode || strobe_rise)
        hop_q <= hop_raw;
    end
  end

  // all outputs are flopped, so pin drive lags the field by one cycle
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      gpio_out_q <= '0;
      gpio_oe_q <= '0;
      pos_out_q <= 1'b0;
      pos_oe_q <= 1'b0;
      neg_out_q <= 1'b0;
      neg_oe_q <= 1'b0;
      slave_q <= 1'b0;
      tx_en_1_q <= 1'b0;
      tx_en_3_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      gpio_out_q <= pin_out_d;
      gpio_oe_q <= pin_oe_d;
      pos_out_q <= pos_out_d;
      pos_oe_q <= pos_oe_d;
      neg_out_q <= neg_out_d;
      neg_oe_q <= neg_oe_d;
      slave_q <= |slave_hit;
      tx_en_1_q <= tx_en_1_lvl;
      tx_en_3_q <= tx_en_3_lvl;
      if (reg_rd_in)
        rdata_q <= rdata_d;
    end
  end

  assign gpio_out = gpio_out_q;
  assign gpio_oe_out = gpio_oe_q;
  assign sync_pos_out = pos_out_q;
  assign sync_pos_oe_out = pos_oe_q;
  assign sync_neg_out = neg_out_q;
  assign sync_neg_oe_out = neg_oe_q;
  assign nco_slave_out = slave_q;
  assign transmit_enable_1_out = tx_en_1_q;
  assign transmit_enable_3_out = tx_en_3_q;
  assign hop_select_out = hop_q;
  assign reg_rdata_out = rdata_q;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_sync_write;
    reg_wr_in && (reg_addr_in == `GPSM_ADDR_SYNC_PORT);
  endsequence
  sequence s_strobe_edge;
    strobe_mode && pin_s[5] && !strobe_prev_q;
  endsequence

  AST_MASTER_PIN0: assert property (
    (field[0] == `GPSM_CODE_MASTER) |=> gpio_oe_out[0]
      && (gpio_out[0] == $past(nco_master_in)))
    else $error("pin 0 not driving master sync");
  AST_SLAVE_PIN2: assert property (
    (field[2] == `GPSM_CODE_SLAVE) |=> !gpio_oe_out[2])
    else $error("slave input pin is driven");
  AST_STROBE_LATCH: assert property (
    s_strobe_edge ##1 (strobe_mode && !$rose(pin_s[5]))[*2]
      |-> $stable(hop_select_out))
    else $error("hop selects moved without a strobe edge");
  AST_NEG_FIELD: assert property (
    s_sync_write |=> sync_port_neg_function_field == $past(reg_wdata_in[7:4]))
    else $error("negative pin field not written");
  AST_POS_FIELD: assert property (
    s_sync_write |=> sync_port_pos_function_field == $past(reg_wdata_in[3:0]))
    else $error("positive pin field not written");
  AST_MODE_BIT: assert property (
    reg_wr_in && (reg_addr_in == `GPSM_ADDR_SYNC_MODE)
      |=> sync_port_differential_mode_q == $past(reg_wdata_in[0]))
    else $error("sync port mode bit not written");
  AST_NEG_HIZ: assert property (
    (sync_port_neg_function_field == `GPSM_CODE_HIZ)
      && !sync_port_differential_mode_q |=> !sync_neg_oe_out)
    else $error("negative pin driven in single-ended high-z");
  AST_NEG_INPUT: assert property (
    (sync_port_neg_function_field == `GPSM_CODE_1) |=> !sync_neg_oe_out)
    else $error("negative pin driven while an input");
  AST_POS_SINGLE: assert property (
    (sync_port_pos_function_field == `GPSM_CODE_1) |=> sync_pos_oe_out
      && (sync_pos_out == $past(second_sync_request_in)))
    else $error("positive pin not driving sync request");
  AST_DIFF_PAIR: assert property (
    neg_diff |=> sync_pos_oe_out && sync_neg_oe_out
      && (sync_neg_out != sync_pos_out))
    else $error("differential pair not complementary");
  AST_TX_EN_1_STATUS: assert property (
    reg_rd_in && (reg_addr_in == `GPSM_ADDR_STATUS0)
      |=> reg_rdata_out[7] == $past(tx_en_1_lvl))
    else $error("status bit 7 wrong");
endmodule

// [verification/gpsm_board.sv]
// board-level pin model: external drivers plus weak pull-downs
module gpsm_board
(
  input wire logic [7:0] dut_val_in,
  input wire logic [7:0] dut_oe_in,
  input wire logic [7:0] ext_val_in,
  input wire logic [7:0] ext_oe_in,
  output logic [7:0] level_out,
  output logic clash_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // a released line falls to the pull-down, never keeps a stale value
  assign level_out = (dut_oe_in & dut_val_in) | (ext_oe_in & ext_val_in);
  assign clash_out = |(dut_oe_in & ext_oe_in);
endmodule

// [verification/testbench.sv]
// self-checking bench for the pin function multiplexer
`include "gpsm_cfg.svh"
module testbench
  import gpsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [11:0] addr;
    gpsm_byte_t data;
    logic mode;
    gpsm_byte_t oe;
    gpsm_byte_t val;
  } gpsm_row_t;
  // bit order of pin vectors: {neg, pos, gpio[5:0]}
  localparam gpsm_row_t rows[12] = '{
    '{12'h035, 8'h0A, 1'b0, 8'h01, 8'h01},
    '{12'h035, 8'h11, 1'b0, 8'h03, 8'h01},
    '{12'h036, 8'h21, 1'b0, 8'h0C, 8'h04},
    '{12'h037, 8'hAA, 1'b0, 8'h30, 8'h30},
    '{12'h038, 8'h01, 1'b0, 8'h40, 8'h40},
    '{12'h038, 8'h09, 1'b1, 8'hC0, 8'h40},
    '{12'h038, 8'h09, 1'b0, 8'h00, 8'h00},
    '{12'h038, 8'h90, 1'b1, 8'h00, 8'h00},
    '{12'h036, 8'hBB, 1'b0, 8'h00, 8'h00},
    '{12'h036, 8'h12, 1'b0, 8'h00, 8'h00},
    '{12'h037, 8'h33, 1'b0, 8'h00, 8'h00},
    '{12'h038, 8'h22, 1'b0, 8'h00, 8'h00}
  };
  localparam logic [11:0] cfg_addrs[5] = '{12'h035, 12'h036, 12'h037,
    12'h038, 12'h42A};
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  gpsm_byte_t reg_wdata = 8'h00;
  gpsm_byte_t reg_rdata;
  gpsm_byte_t dut_val;
  gpsm_byte_t dut_oe;
  gpsm_byte_t level;
  gpsm_byte_t ext_val = 8'h00;
  gpsm_byte_t ext_oe = 8'h00;
  logic [3:0] amp = 4'h5;
  logic master = 1'b1;
  logic request = 1'b1;
  logic slave;
  logic tx_en_1;
  logic tx_en_3;
  logic [6:0] hop;
  logic clash;
  int num_errors = 0;
  int comparisons = 0;

  gpsm_mux u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
    .gpio_in(level[5:0]), .gpio_out(dut_val[5:0]),
    .gpio_oe_out(dut_oe[5:0]), .sync_pos_in(level[6]),
    .sync_pos_out(dut_val[6]), .sync_pos_oe_out(dut_oe[6]),
    .sync_neg_in(level[7]), .sync_neg_out(dut_val[7]),
    .sync_neg_oe_out(dut_oe[7]), .power_amp_enable_in(amp),
    .nco_master_in(master), .nco_slave_out(slave),
    .second_sync_request_in(request), .transmit_enable_1_out(tx_en_1),
    .transmit_enable_3_out(tx_en_3), .hop_select_out(hop));
  gpsm_board u_board (.dut_val_in(dut_val), .dut_oe_in(dut_oe),
    .ext_val_in(ext_val), .ext_oe_in(ext_oe), .level_out(level),
    .clash_out(clash));

  initial
  begin
    forever #20 clk_in = ~clk_in;
  end

  task automatic check(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input gpsm_byte_t d);
    @(negedge clk_in);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_in);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input gpsm_byte_t e);
    @(negedge clk_in);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_in);
    reg_rd = 1'b0;
    check("rdata", e, reg_rdata);
  endtask

  // pins pass two sync flops and an output flop, so allow five edges
  task automatic settle();
    repeat (5) @(negedge clk_in);
  endtask

  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #(40 * 5000);
    num_errors++;
    final_report();
  end

  initial
  begin
    repeat (4) @(negedge clk_in);
    reset_n_in = 1'b1;
    check("oe after reset", 8'h00, dut_oe);
    foreach (cfg_addrs[i]) rd(cfg_addrs[i], 8'h00);
    foreach (rows[i])
    begin
      foreach (cfg_addrs[j]) wr(cfg_addrs[j], 8'h00);
      wr(rows[i].addr, rows[i].data);
      wr(`GPSM_ADDR_SYNC_MODE, {7'h00, rows[i].mode});
      settle();
      check("pin oe", rows[i].oe, dut_oe);
      check("pin val", rows[i].val, dut_val & dut_oe);
    end
    // hop selects follow their pins while no strobe is configured
    wr(12'h035, 8'h33);
    wr(12'h036, 8'h33);
    wr(12'h037, 8'h02);
    wr(12'h038, 8'h13);
    ext_oe = 8'hFF;
    ext_val = 8'h55;
    settle();
    check("hop", 8'h55, {1'b0, hop});
    rd(`GPSM_ADDR_STATUS0, 8'h22);
    rd(`GPSM_ADDR_STATUS1, 8'h09);
    wr(12'h037, 8'h22);
    ext_val = 8'h8A;
    settle();
    check("hop held", 8'h55, {1'b0, hop});
    rd(`GPSM_ADDR_STATUS1, 8'h10);
    ext_val = 8'hAA;
    settle();
    check("hop strobed", 8'h2A, {1'b0, hop});
    rd(`GPSM_ADDR_STATUS1, 8'h14);
    // slave input on pin 3, transmit enables on pins 4 and 5
    wr(12'h036, 8'hB0);
    wr(12'h037, 8'h11);
    ext_val = 8'h18;
    settle();
    check("slave", 8'h01, {7'h00, slave});
    check("clash", 8'h00, {7'h00, clash});
    check("txen", 8'h01, {6'h00, tx_en_3, tx_en_1});
    rd(`GPSM_ADDR_STATUS0, 8'h80);
    ext_val = 8'h20;
    settle();
    check("slave low", 8'h00, {7'h00, slave});
    check("txen swap", 8'h02, {6'h00, tx_en_3, tx_en_1});
    rd(`GPSM_ADDR_STATUS1, 8'h02);
    ext_oe = 8'h00;
    // readback, reserved mode bits and an unmapped address
    wr(12'h036, 8'h5A);
    wr(12'h038, 8'h3C);
    wr(`GPSM_ADDR_SYNC_MODE, 8'hFF);
    wr(12'h100, 8'hFF);
    rd(12'h036, 8'h5A);
    rd(12'h038, 8'h3C);
    rd(`GPSM_ADDR_SYNC_MODE, 8'h01);
    rd(12'h100, 8'h00);
    // core levels flipped: pin drive must follow them, not a constant
    request = 1'b0;
    master = 1'b0;
    amp = 4'hA;
    wr(12'h035, 8'h1A);
    wr(12'h038, 8'h09);
    settle();
    check("oe flipped", 8'hC7, dut_oe);
    check("val flipped", 8'h82, dut_val & dut_oe);
    // reset in mid-run returns every pin to high-z
    wr(12'h035, 8'h0A);
    settle();
    reset_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    check("oe in reset", 8'h00, dut_oe);
    reset_n_in = 1'b1;
    foreach (cfg_addrs[i]) rd(cfg_addrs[i], 8'h00);
    final_report();
  end
endmodule
